// *** testbench/pzs_host_model.sv ***
/* Host controller model: tone and select pins.
   Assumes the bench calls its tasks; pins change just after clk_i rises. */
`timescale 1ns/100ps
module pzs_host_model (
  input  wire logic clk_i,
  output logic      tone_o,
  output logic      scl_o,
  output logic      sda_o,
  output logic      rm_o
);
  initial begin
    tone_o = 1'b0;
    scl_o  = 1'b0;
    sda_o  = 1'b0;
    rm_o   = 1'b0;
  end
  // Halves of six cycles outlast the input filter
  task automatic pulses(input int n);
    repeat (n) begin
      @(posedge clk_i) tone_o <= 1'b1;
      repeat (6) @(posedge clk_i);
      tone_o <= 1'b0;
      repeat (6) @(posedge clk_i);
    end
  endtask
  task automatic hold(input logic v, input int n);
    @(posedge clk_i) tone_o <= v;
    repeat (n) @(posedge clk_i);
  endtask
  task automatic pins(input logic c, input logic d, input logic r);
    @(posedge clk_i) scl_o <= c;
    sda_o <= d;
    rm_o <= r;
  endtask
endmodule

// *** testbench/pzs_sequencer_sva.sv ***
/* Port checker for the piezo sequencer.
   Assumes tone pulses last several cycles, so the synchroniser sees each one. */
`timescale 1ns/100ps
`include "pzs_cfg.svh"
module pzs_sequencer_sva #(
  parameter int OFF_CYCLES = `PZS_OFF_CYCLES,
  parameter int RAMP_W     = `PZS_RAMP_W,
  parameter int STEP_CYC   = `PZS_RAMP_STEP_CYC
) (
  input wire logic                   clk_i,
  input wire logic                   rst_i,
  input wire logic                   tone_i,
  input wire logic                   scl_i,
  input wire logic                   sda_i,
  input wire logic                   regulation_select_i,
  input wire logic                   rail_good_i,
  input wire logic                   boost_en_o,
  input wire logic [RAMP_W-1:0]      boost_strength_o,
  input wire logic [`PZS_LEVEL_W-1:0] boost_level_o,
  input wire logic                   reg_const_v_o,
  input wire logic                   drive_en_o,
  input wire logic                   drive_out_true_o,
  input wire logic                   drive_out_inverted_o,
  input wire logic                   pulldown_en_o,
  input wire logic                   active_o
);
  int low_reg;
  int low_next;
  // Saturates so a long shutdown never wraps the count
  always_comb begin
    low_next = tone_i ? 0 : low_reg + 1;
    if (low_reg > OFF_CYCLES + 20) low_next = low_reg;
  end
  always_ff @(posedge clk_i) begin
    low_reg <= rst_i ? 0 : low_next;
  end
  function automatic logic [2:0] lvl(input logic c, input logic d);
    case ({c, d})
      2'b00: return `PZS_LEVEL_LL;
      2'b10: return `PZS_LEVEL_HL;
      2'b11: return `PZS_LEVEL_HH;
      default: return `PZS_LEVEL_LH;
    endcase
  endfunction
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_steady; $stable({scl_i, sda_i, regulation_select_i})[*8]; endsequence
  sequence s_ramp; (boost_en_o && !drive_en_o && !rail_good_i && boost_strength_o != '1)[*8];
  endsequence
  property p_gate; !drive_en_o |-> !drive_out_true_o && !drive_out_inverted_o; endproperty
  a_gate: assert property (p_gate) else $error("drive active while disabled");
  property p_excl; drive_out_true_o |-> !drive_out_inverted_o; endproperty
  a_excl: assert property (p_excl) else $error("drive outputs not complementary");
  property p_chain; drive_en_o |-> boost_en_o && active_o; endproperty
  a_chain: assert property (p_chain) else $error("drive without boost");
  property p_pd; pulldown_en_o |-> !boost_en_o && !drive_en_o; endproperty
  a_pd: assert property (p_pd) else $error("pulldown while running");
  property p_level; s_steady |-> boost_level_o == lvl(scl_i, sda_i); endproperty
  a_level: assert property (p_level) else $error("level code wrong");
  property p_rm; s_steady |-> reg_const_v_o == regulation_select_i; endproperty
  a_rm: assert property (p_rm) else $error("regulation mode wrong");
  property p_ramp; s_ramp |-> boost_strength_o != $past(boost_strength_o, 7); endproperty
  a_ramp: assert property (p_ramp) else $error("soft start stalled");
  property p_start; $rose(boost_en_o) |-> !drive_en_o ##1 !drive_en_o; endproperty
  a_start: assert property (p_start) else $error("drive before soft start");
  property p_off; low_reg == OFF_CYCLES + 10 |-> !boost_en_o && !drive_en_o && pulldown_en_o;
  endproperty
  a_off: assert property (p_off) else $error("no shutdown after low time");
  property p_stay; boost_en_o && low_reg < OFF_CYCLES |=> boost_en_o; endproperty
  a_stay: assert property (p_stay) else $error("early shutdown");
endmodule
bind pzs_sequencer pzs_sequencer_sva #(
  .OFF_CYCLES(OFF_CYCLES), .RAMP_W(RAMP_W), .STEP_CYC(STEP_CYC)
) u_sva (
  .clk_i(clk_i), .rst_i(rst_i), .tone_i(tone_i), .scl_i(scl_i), .sda_i(sda_i),
  .regulation_select_i(regulation_select_i), .rail_good_i(rail_good_i),
  .boost_en_o(boost_en_o), .boost_strength_o(boost_strength_o),
  .boost_level_o(boost_level_o), .reg_const_v_o(reg_const_v_o), .drive_en_o(drive_en_o),
  .drive_out_true_o(drive_out_true_o), .drive_out_inverted_o(drive_out_inverted_o),
  .pulldown_en_o(pulldown_en_o), .active_o(active_o)
);

// *** testbench/test_piezo_drive_mode_sequencer.sv ***
/* Bench for the piezo sequencer with a host model.
   Assumes rail_good is the analog comparator, driven here. */
`timescale 1ns/100ps
module test_piezo_drive_mode_sequencer;
  localparam int OFF = 50;
  logic       clk_i = 1'b0;
  logic       rst_i = 1'b1;
  logic       rail_good = 1'b0;
  logic       tone, scl, sda, rm;
  logic       boost, cv, drv, d_t, d_n, pd, act;
  logic [7:0] strength;
  logic [2:0] level;
  int         failures = 0;
  int         n_compared = 0;
  always #20 clk_i = ~clk_i;
  pzs_host_model host (.clk_i(clk_i), .tone_o(tone), .scl_o(scl), .sda_o(sda), .rm_o(rm));
  pzs_sequencer #(.OFF_CYCLES(OFF), .STEP_CYC(4)) uut (
    .clk_i(clk_i), .rst_i(rst_i), .tone_i(tone), .scl_i(scl), .sda_i(sda),
    .regulation_select_i(rm), .rail_good_i(rail_good), .boost_en_o(boost),
    .boost_strength_o(strength), .boost_level_o(level), .reg_const_v_o(cv),
    .drive_en_o(drv), .drive_out_true_o(d_t), .drive_out_inverted_o(d_n),
    .pulldown_en_o(pd), .active_o(act)
  );
  task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic end_of_test();
    $display("compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic t_reset();
    chk("pulldown", pd, 8'h01);
    chk("active", act, 8'h00);
    chk("run", {boost, drv, d_t, d_n}, 8'h00);
    chk("level", level, 8'h07);
  endtask
  task automatic t_levels();
    logic [2:0] exp [4] = '{3'h7, 3'h1, 3'h5, 3'h3};
    for (int i = 0; i < 4; i++) begin
      host.pins(i[1], i[0], i[0]);
      repeat (10) @(posedge clk_i);
      chk("level", level, exp[i]);
      chk("reg_mode", cv, i[0]);
    end
  endtask
  task automatic t_wake();
    host.pulses(2);
    chk("active", act, 8'h01);
    chk("boost_early", boost, 8'h00);
    host.pulses(1);
    chk("boost", boost, 8'h01);
    chk("pulldown_off", pd, 8'h00);
    host.hold(1'b1, 30);
    chk("ramp", strength > 8'h00, 8'h01);
    chk("drive_held", {drv, d_t, d_n}, 8'h00);
    rail_good <= 1'b1;
    repeat (10) @(posedge clk_i);
    chk("drive_en", drv, 8'h01);
    chk("tone_high", {d_t, d_n}, 8'h02);
    host.hold(1'b0, 8);
    chk("tone_low", {d_t, d_n}, 8'h01);
  endtask
  task automatic t_cancel();
    host.hold(1'b0, 30);
    host.hold(1'b1, 6);
    host.hold(1'b0, 30);
    chk("still_on", {boost, drv}, 8'h03);
    host.hold(1'b0, OFF + 10);
    chk("off", {boost, drv, d_t, d_n, act}, 8'h00);
    chk("pulldown", pd, 8'h01);
  endtask
  task automatic t_rewake();
    rail_good <= 1'b0;
    host.pulses(2);
    chk("count_cleared", boost, 8'h00);
    host.pulses(1);
    chk("boost_again", boost, 8'h01);
    chk("new_soft_start", drv, 8'h00);
  endtask
  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    t_reset();
    t_levels();
    t_wake();
    t_cancel();
    t_rewake();
    end_of_test();
  end
  // Run takes about 315 cycles
  initial begin
    #(40 * 5000);
    failures++;
    end_of_test();
  end
endmodule

// *** verilog/pzs_cfg.svh ***
/*
  Constants for the piezo drive mode sequencer: timing counts, level codes,
  and select decoding.
  Assumes a 25 MHz system clock; included by bare name.
*/
`ifndef PZS_CFG_SVH
`define PZS_CFG_SVH

`define PZS_CLK_HZ          25000000
`define PZS_OFF_DELAY_MS    10
`define PZS_OFF_CYCLES      ((`PZS_CLK_HZ / 1000) * `PZS_OFF_DELAY_MS)
`define PZS_START_EDGES     3
`define PZS_EDGE_CNT_W      2
`define PZS_LEVEL_W         3
`define PZS_LEVEL_LL        3'h7
`define PZS_LEVEL_HL        3'h5
`define PZS_LEVEL_HH        3'h3
`define PZS_LEVEL_LH        3'h1
`define PZS_LEVEL_RESET     3'h7
`define PZS_RAMP_W          8
`define PZS_RAMP_STEP_CYC   256

`endif

// *** verilog/pzs_pkg.sv ***
/*
  Types for the piezo drive mode sequencer.
  Assumes nothing beyond the constants header.
*/
package pzs_pkg;
  typedef enum logic [1:0] {
    PZS_SHUTDOWN,
    PZS_ARMING,
    PZS_RAMPING,
    PZS_DRIVING
  } pzs_state_t;

  typedef enum logic {
    PZS_REG_RATIO,
    PZS_REG_CONST_V
  } pzs_reg_mode_t;
endpackage

// *** verilog/pzs_sequencer.sv ***
/*
  Piezo drive mode sequencer top: tone edge counting, boost start, soft-start,
  output gating, low-time shutdown and pin-controlled level selection.
  Each group of state has one next-value process and one register process;
  every top-level output is taken straight from a register.
  Assumes tone, bus select pins, regulation select and rail comparator are
  asynchronous pins; analog drivers honour the enables and pull-down request.
  The pull-down request stands for a weak path of the pad, not a driven low.
  Input filters add about four cycles, so tone edges need several cycles.
*/
`timescale 1ns/100ps
`include "pzs_cfg.svh"
module pzs_sequencer
  import pzs_pkg::*;
#(
  parameter int OFF_CYCLES = `PZS_OFF_CYCLES,
  parameter int RAMP_W     = `PZS_RAMP_W,
  parameter int STEP_CYC   = `PZS_RAMP_STEP_CYC
) (
  input  wire logic                    clk_i,
  input  wire logic                    rst_i,
  input  wire logic                    tone_i,
  input  wire logic                    scl_i,
  input  wire logic                    sda_i,
  input  wire logic                    regulation_select_i,
  input  wire logic                    rail_good_i,
  output logic                         boost_en_o,
  output logic [RAMP_W-1:0]            boost_strength_o,
  output logic [`PZS_LEVEL_W-1:0]      boost_level_o,
  output logic                         reg_const_v_o,
  output logic                         drive_en_o,
  output logic                         drive_out_true_o,
  output logic                         drive_out_inverted_o,
  output logic                         pulldown_en_o,
  output logic                         active_o
);
  localparam int OFF_W  = $clog2(OFF_CYCLES + 1);
  localparam int N_PINS = 5;

  logic [N_PINS-1:0]        pin_raw;
  logic [N_PINS-1:0]        pin_s;
  logic                     shut_now;
  logic                     act_reg;
  logic                     act_next;
  logic [RAMP_W-1:0]        str_next;

  logic                     tone_s;
  logic                     scl_s;
  logic                     sda_s;
  logic                     rm_s;
  logic                     good_s;
  logic [RAMP_W-1:0]        ramp_str;
  logic                     ramp_done;

  pzs_state_t               state_reg;
  pzs_state_t               state_next;
  logic                     tone_d_reg;
  logic [`PZS_EDGE_CNT_W-1:0] edge_reg;
  logic [`PZS_EDGE_CNT_W-1:0] edge_next;
  logic [OFF_W-1:0]         off_reg;
  logic [OFF_W-1:0]         off_next;
  logic                     boost_reg;
  logic                     boost_next;
  logic                     den_reg;
  logic                     den_next;
  logic                     dt_reg;
  logic                     dt_next;
  logic                     di_reg;
  logic                     di_next;
  logic                     pd_reg;
  logic                     pd_next;
  logic [`PZS_LEVEL_W-1:0]  lvl_reg;
  logic [`PZS_LEVEL_W-1:0]  lvl_next;
  logic                     rm_reg;
  logic                     rm_next;
  logic [RAMP_W-1:0]        str_reg;
  logic                     rise;
  logic                     off_expired;

  // Every pin idles low, so all filters start from zero
  assign pin_raw = {rail_good_i, regulation_select_i, sda_i, scl_i, tone_i};

  generate
    for (genvar gi = 0; gi < N_PINS; gi++) begin : g_sync
      pzs_sync #(
        .INIT (1'b0)
      ) u_sync (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .pin_i   (pin_raw[gi]),
        .level_o (pin_s[gi])
      );
    end
  endgenerate

  assign tone_s = pin_s[0];
  assign scl_s  = pin_s[1];
  assign sda_s  = pin_s[2];
  assign rm_s   = pin_s[3];
  assign good_s = pin_s[4];

  pzs_soft_start #(
    .RAMP_W   (RAMP_W),
    .STEP_CYC (STEP_CYC)
  ) u_soft_start (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .run_i       (boost_reg),
    .rail_good_i (good_s),
    .strength_o  (ramp_str),
    .done_o      (ramp_done)
  );

  assign rise        = tone_s & ~tone_d_reg;
  assign off_expired = (off_reg == OFF_W'(OFF_CYCLES - 1));

  // Low-time countdown group
  always_comb begin
    off_next = off_reg;
    shut_now = 1'b0;
    // Any high tone restarts the low-time measurement
    if (state_reg == PZS_SHUTDOWN) begin
      off_next = '0;
    end else if (tone_s) begin
      off_next = '0;
    end else if (off_expired) begin
      // Tone low for the whole delay forces shutdown from any mode
      off_next = '0;
      shut_now = 1'b1;
    end else begin
      off_next = off_reg + 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      off_reg <= '0;
    end else begin
      off_reg <= off_next;
    end
  end

  // Mode sequencing group
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      PZS_SHUTDOWN: begin
        if (rise) begin
          state_next = PZS_ARMING;
        end
      end
      PZS_ARMING: begin
        // Third rising edge starts the converter
        if (rise && (edge_reg == 2'(`PZS_START_EDGES - 1))) begin
          state_next = PZS_RAMPING;
        end
      end
      PZS_RAMPING: begin
        // Drivers held off until the rail is up
        if (ramp_done) begin
          state_next = PZS_DRIVING;
        end
      end
      PZS_DRIVING: begin
        // Tone passes through; only the countdown leaves this state
      end
      default: begin
        state_next = PZS_SHUTDOWN;
      end
    endcase
    if (shut_now) begin
      state_next = PZS_SHUTDOWN;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg  <= PZS_SHUTDOWN;
      tone_d_reg <= 1'b0;
    end else begin
      state_reg  <= state_next;
      tone_d_reg <= tone_s;
    end
  end

  // Rising-edge counter group
  always_comb begin
    edge_next = edge_reg;
    if (shut_now) begin
      // Next wake needs three fresh edges
      edge_next = '0;
    end else if (rise && (state_reg == PZS_SHUTDOWN)) begin
      edge_next = 2'h1;
    end else if (rise && (state_reg == PZS_ARMING)) begin
      edge_next = edge_reg + 2'h1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      edge_reg <= '0;
    end else begin
      edge_reg <= edge_next;
    end
  end

  // Converter and driver enable group
  always_comb begin
    // Converter runs through ramp and drive; both fall with shutdown
    boost_next = (state_next == PZS_RAMPING) || (state_next == PZS_DRIVING);
    // Drivers only once the rail is up
    den_next   = (state_next == PZS_DRIVING);
    // Strength is shown only while the converter runs
    str_next   = boost_next ? ramp_str : '0;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      boost_reg <= 1'b0;
      den_reg   <= 1'b0;
      str_reg   <= '0;
    end else begin
      boost_reg <= boost_next;
      den_reg   <= den_next;
      str_reg   <= str_next;
    end
  end

  // Drive output group
  always_comb begin
    // Complement only while enabled; idle both low
    dt_next  = den_next & tone_s;
    di_next  = den_next & ~tone_s;
    // Weak pull-down in shutdown
    pd_next  = (state_next == PZS_SHUTDOWN);
    act_next = (state_next != PZS_SHUTDOWN);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dt_reg  <= 1'b0;
      di_reg  <= 1'b0;
      pd_reg  <= 1'b1;
      act_reg <= 1'b0;
    end else begin
      dt_reg  <= dt_next;
      di_reg  <= di_next;
      pd_reg  <= pd_next;
      act_reg <= act_next;
    end
  end

  // Regulation style group
  always_comb begin
    // High pin is constant voltage, low is constant ratio
    rm_next = rm_s;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rm_reg <= 1'b0;
    end else begin
      rm_reg <= rm_next;
    end
  end

  // Level select group
  always_comb begin
    // Pin control is the only mode here, so every reset lands in it
    if (!scl_s && !sda_s) begin
      lvl_next = `PZS_LEVEL_LL;
    end else if (scl_s && !sda_s) begin
      lvl_next = `PZS_LEVEL_HL;
    end else if (scl_s && sda_s) begin
      lvl_next = `PZS_LEVEL_HH;
    end else begin
      lvl_next = `PZS_LEVEL_LH;
    end
    // Four-way map
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lvl_reg <= `PZS_LEVEL_RESET;
    end else begin
      lvl_reg <= lvl_next;
    end
  end

  assign boost_en_o           = boost_reg;
  assign boost_strength_o     = str_reg;
  assign boost_level_o        = lvl_reg;
  assign reg_const_v_o        = rm_reg;
  assign drive_en_o           = den_reg;
  assign drive_out_true_o     = dt_reg;
  assign drive_out_inverted_o = di_reg;
  assign pulldown_en_o        = pd_reg;
  assign active_o             = act_reg;
endmodule

// *** verilog/pzs_soft_start.sv ***
/*
  Soft-start ramp for the boost rail: raises the rail drive strength one step
  per tick toward full and flags when the rail reaches its target.
  Assumes rail_good_i is a synchronised comparator result from the analog side.
*/
`timescale 1ns/100ps
`include "pzs_cfg.svh"
module pzs_soft_start
  import pzs_pkg::*;
#(
  parameter int RAMP_W    = `PZS_RAMP_W,
  parameter int STEP_CYC  = `PZS_RAMP_STEP_CYC
) (
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire logic              run_i,
  input  wire logic              rail_good_i,
  output logic [RAMP_W-1:0]      strength_o,
  output logic                   done_o
);
  localparam int DIV_W = $clog2(STEP_CYC);

  logic [DIV_W-1:0]  div_reg;
  logic [DIV_W-1:0]  div_next;
  logic [RAMP_W-1:0] str_reg;
  logic [RAMP_W-1:0] str_next;
  logic              done_reg;
  logic              done_next;
  logic              tick;

  always_comb begin
    tick      = (div_reg == DIV_W'(STEP_CYC - 1));
    div_next  = tick ? '0 : div_reg + 1'b1;
    str_next  = str_reg;
    done_next = done_reg;
    if (!run_i) begin
      div_next  = '0;
      str_next  = '0;
      done_next = 1'b0;
    end else begin
      // Strength climbs in steps, never jumps to full
      if (tick && (str_reg != {RAMP_W{1'b1}})) begin
        str_next = str_reg + 1'b1;
      end
      if (rail_good_i) begin
        done_next = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      div_reg  <= '0;
      str_reg  <= '0;
      done_reg <= 1'b0;
    end else begin
      div_reg  <= div_next;
      str_reg  <= str_next;
      done_reg <= done_next;
    end
  end

  assign strength_o = str_reg;
  assign done_o     = done_reg;
endmodule

// *** verilog/pzs_sync.sv ***
/*
  Three-flop input synchroniser with agreement filter.
  Assumes an asynchronous pin input and the single system clock.
*/
`timescale 1ns/100ps
module pzs_sync #(
  parameter logic INIT = 1'b0
) (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic pin_i,
  output logic      level_o
);
  logic [2:0] pipe_reg;
  logic [2:0] pipe_next;
  logic       level_reg;
  logic       level_next;

  always_comb begin
    pipe_next  = {pipe_reg[1:0], pin_i};
    level_next = level_reg;
    // Only stages two and three are compared; stage one may be metastable
    if (pipe_reg[1] == pipe_reg[2]) begin
      level_next = pipe_reg[2];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pipe_reg  <= {3{INIT}};
      level_reg <= INIT;
    end else begin
      pipe_reg  <= pipe_next;
      level_reg <= level_next;
    end
  end

  assign level_o = level_reg;
endmodule
